/* core/gic_pkg.sv */
// Shared constants, types and carriers of the gate input and menu controller
package gic_pkg;
   // ***************************************************
   // Clock and time base
   // ***************************************************
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int TW = 18;
   localparam int PROG_HOLD_MS = 1000;
   localparam int EDIT_HOLD_MS = 1000;
   localparam int IDLE_MIN = 3;
   localparam int REV_MS = 500;
   localparam int MS_PER_S = 1000;
   localparam logic [TW-1:0] PROG_HOLD_T = TW'(PROG_HOLD_MS / TICK_MS);
   localparam logic [TW-1:0] EDIT_HOLD_T = TW'(EDIT_HOLD_MS / TICK_MS);
   localparam logic [TW-1:0] IDLE_T = TW'(IDLE_MIN * 60 * 1000 / TICK_MS);
   localparam logic [TW-1:0] REV_T = TW'(REV_MS / TICK_MS);
   localparam logic [TW-1:0] SEC_T = TW'(MS_PER_S / TICK_MS);
   localparam int BLINK_BIT = 8;
   // ***************************************************
   // Programming functions and options
   // ***************************************************
   localparam int NFUNC = 8;
   localparam int OPT_W = 4;
   localparam logic [OPT_W-1:0] OPT_RESET = 4'h0;
   localparam int FN_HAND = 0;
   localparam int FN_SINGLE = 1;
   localparam int FN_AUX = 2;
   localparam int FN_AUTOCLOSE = 3;
   localparam logic [1:0] AUX_OFF = 2'h0;
   localparam logic [1:0] AUX_MAGLOCK = 2'h1;
   localparam logic [1:0] AUX_STROBE = 2'h2;
   localparam logic [1:0] AUX_TICKET = 2'h3;
   // ***************************************************
   // Register map
   // ***************************************************
   localparam int AW = 12;
   localparam logic [AW-1:0] REG_STATUS = 12'h000;
   localparam logic [AW-1:0] REG_INPUTS = 12'h004;
   localparam logic [AW-1:0] REG_OPT0 = 12'h010;
   localparam int ST_GATE_POS = 0;
   localparam int ST_LOCK_POS = 4;
   localparam int ST_PROG_POS = 5;
   localparam int ST_MENU_POS = 8;
   localparam int ST_FUNC_POS = 12;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ***************************************************
   // Types
   // ***************************************************
   typedef enum logic [2:0] {G_CLOSED, G_OPENING, G_OPEN, G_CLOSING, G_STOP, G_REV, G_LOCK} gic_gate_st_t;
   typedef enum logic [2:0] {M_IDLE, M_FUNC, M_SHOW, M_EDIT, M_STORED} gic_menu_st_t;
   typedef struct packed {
      logic sta_open;
      logic sta_close;
      logic sta_stop;
      logic single;
      logic opening_obstruct_in;
      logic closing_obstruct_in;
      logic reversal_contact_in;
      logic exit_loop;
      logic reverse_loop;
      logic shadow_loop;
      logic open_limit;
      logic close_limit;
      logic lock_reset;
      logic btn_up;
      logic btn_down;
      logic btn_enter;
   } gic_in_t;
endpackage

/* core/gic_gate_ctrl.sv */
// Gate input handling, motion control and programming menu with AXI4-Lite registers
//
// Function
// R1 - Open, close and stop station presses command matching gate motion.
// R2 - Held open input overrides mid-travel stop and suspends auto-close.
// R3 - Opening obstruction while moving: stop, reverse briefly, stop.
// R4 - After reversal auto-close is disabled; gate waits for a fresh command.
// R5 - Repeat obstruction before a limit: stop, lockout, sound alarm.
// R6 - Closing obstruction behaves the same during closing travel.
// R7 - Reversal contact during closing drives the gate fully open.
// R8 - Reverse loop during closing drives the gate fully open.
// R9 - Exit loop opens the gate and holds it open while triggered.
// R10 - Shadow loop holds the gate fully open while present.
// R11 - Auxiliary relay with NO/NC contacts follows gate operation.
// R12 - Up and down held one second enters programming; indicator lit.
// R13 - Up and down together exits; three idle minutes also exit.
// R14 - Up/down step functions; enter shows the current option.
// R15 - Decimal points lit whenever an option is shown.
// R16 - Enter held one second starts flashing edit; up/down cycle options.
// R17 - Enter in edit stores option; then enter/up/down return to functions.
// R18 - Right-hand by default; left-hand option mirrors motor direction.
// R19 - Single button alternates open/close or cycles open-stop-close-stop.
// R20 - All inputs synchronised and debounced before use.
// R21 - Lockout blocks all motion until the reset input is pressed.
`timescale 1ns/1ps
module gic_gate_ctrl
   import gic_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Field contacts, limits and panel buttons
   input wire gic_in_t field_in,
   // Motor drive
   output logic motor_open_r,
   output logic motor_close_r,
   // Alarm beeper and auxiliary relay contacts
   output logic alarm_r,
   output logic aux_no_closed_r,
   output logic aux_nc_closed_r,
   // Programming panel
   output logic prog_led_r,
   output logic disp_dp_r,
   output logic disp_on_r,
   output logic [3:0] disp_code_r,
   // AXI4-Lite slave
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int NIN = $bits(gic_in_t);

   // ***************************************************
   // Helper functions
   // ***************************************************
   // Option window hit for a byte address
   function automatic logic opt_hit(input logic [AW-1:0] a);
      logic [AW-1:0] d;
      d = a - REG_OPT0;
      return (a >= REG_OPT0) && (d[AW-1:2] < 10'(NFUNC));
   endfunction

   // Option index for a byte address inside the window
   function automatic logic [2:0] opt_idx(input logic [AW-1:0] a);
      logic [AW-1:0] d;
      d = a - REG_OPT0;
      return d[4:2];
   endfunction

   // Wrapping up/down step of a menu value
   function automatic logic [3:0] step4(input logic [3:0] v, input logic up);
      return up ? 4'(v + 4'h1) : 4'(v - 4'h1);
   endfunction

   // ***************************************************
   // Time base and input conditioning
   // ***************************************************
   logic [15:0] tick_cnt_r;
   logic tick_r;
   logic [NIN-1:0] sync1_r, sync2_r, samp_r, deb_r, deb_d_r;
   wire tick_end = tick_cnt_r == 16'(TICK_CYCLES - 1);
   wire [NIN-1:0] stable = ~(samp_r ^ sync2_r);

   // One tick per millisecond paces debounce and every timer
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_r <= 16'h0000;
         tick_r <= 1'b0;
      end else begin
         tick_cnt_r <= tick_end ? 16'h0000 : 16'(tick_cnt_r + 16'h0001);
         tick_r <= tick_end;
      end
   end

   // Two samples a tick apart must agree before a level is believed
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= '0;
         sync2_r <= '0;
         samp_r <= '0;
         deb_r <= '0;
         deb_d_r <= '0;
      end else begin
         sync1_r <= field_in; // R20
         sync2_r <= sync1_r;
         deb_d_r <= deb_r;
         if (tick_r) begin
            samp_r <= sync2_r;
            deb_r <= (stable & sync2_r) | (~stable & deb_r); // R20
         end
      end
   end

   gic_in_t lvl, prs;
   assign lvl = gic_in_t'(deb_r);
   assign prs = gic_in_t'(deb_r & ~deb_d_r);

   // ***************************************************
   // Option store
   // ***************************************************
   logic [OPT_W-1:0] opt_mem [NFUNC];
   wire left_hand = opt_mem[FN_HAND][0];
   wire single_alt = opt_mem[FN_SINGLE][0];
   wire [1:0] aux_mode = opt_mem[FN_AUX][1:0];
   wire [OPT_W-1:0] ac_sec = opt_mem[FN_AUTOCLOSE];
   wire [TW-1:0] ac_load = TW'(ac_sec) * SEC_T;

   // ***************************************************
   // Gate motion control
   // ***************************************************
   gic_gate_st_t st_r, st_nxt;
   logic [TW-1:0] gtim_r, gtim_nxt;
   logic armed_r, armed_nxt, acd_r, acd_nxt, lo_r, lo_nxt, ro_r, ro_nxt;

   // Command decode from debounced presses and levels
   wire moving = (st_r == G_OPENING) || (st_r == G_CLOSING);
   wire sgl_open = prs.single & (single_alt ? (st_r != G_OPEN) :
                   ((st_r == G_CLOSED) || ((st_r == G_STOP) && !lo_r))); // R19
   wire sgl_close = prs.single & (single_alt ? (st_r == G_OPEN) :
                    ((st_r == G_OPEN) || ((st_r == G_STOP) && lo_r))); // R19
   wire sgl_stop = prs.single & !single_alt & moving; // R19
   wire want_open = prs.sta_open | lvl.exit_loop | sgl_open; // R1 R9
   wire cmd_close = prs.sta_close | sgl_close; // R1
   wire want_stop = (prs.sta_stop | sgl_stop) & !lvl.sta_open; // R1 R2
   wire hold_open = lvl.sta_open | lvl.exit_loop | lvl.shadow_loop; // R2 R9 R10
   wire reopen = lvl.reversal_contact_in | lvl.reverse_loop | lvl.shadow_loop | want_open; // R7 R8 R10
   wire ac_fire = !acd_r && (ac_sec != OPT_RESET) && (gtim_r == '0);
   wire gtim_dec = tick_r && (gtim_r != '0);

   // Next state of the gate; obstruction checks take priority over limits
   always_comb begin
      st_nxt = st_r;
      gtim_nxt = gtim_dec ? TW'(gtim_r - 1'b1) : gtim_r;
      armed_nxt = armed_r;
      acd_nxt = acd_r;
      lo_nxt = lo_r;
      ro_nxt = ro_r;
      case (st_r)
         G_CLOSED, G_STOP: begin
            if (want_open) begin
               st_nxt = G_OPENING;
               acd_nxt = 1'b0; // R4
               lo_nxt = 1'b1;
            end else if (cmd_close && (st_r == G_STOP)) begin
               st_nxt = G_CLOSING;
               acd_nxt = 1'b0; // R4
               lo_nxt = 1'b0;
            end
         end
         G_OPENING: begin
            if (lvl.opening_obstruct_in) begin
               if (armed_r) begin
                  st_nxt = G_LOCK; // R5
               end else begin
                  st_nxt = G_REV; // R3
                  ro_nxt = 1'b0;
                  gtim_nxt = REV_T;
                  armed_nxt = 1'b1;
                  acd_nxt = 1'b1; // R4
               end
            end else if (lvl.open_limit) begin
               st_nxt = G_OPEN;
               armed_nxt = 1'b0;
               gtim_nxt = ac_load;
            end else if (want_stop) begin
               st_nxt = G_STOP; // R1
            end else if (cmd_close) begin
               st_nxt = G_CLOSING;
               lo_nxt = 1'b0;
            end
         end
         G_OPEN: begin
            if (hold_open) begin
               gtim_nxt = ac_load; // R2 R9 R10
            end else if (cmd_close || ac_fire) begin
               st_nxt = G_CLOSING;
               lo_nxt = 1'b0;
            end
         end
         G_CLOSING: begin
            if (lvl.closing_obstruct_in) begin
               if (armed_r) begin
                  st_nxt = G_LOCK; // R6
               end else begin
                  st_nxt = G_REV; // R6
                  ro_nxt = 1'b1;
                  gtim_nxt = REV_T;
                  armed_nxt = 1'b1;
                  acd_nxt = 1'b1;
               end
            end else if (reopen) begin
               st_nxt = G_OPENING; // R7 R8
               lo_nxt = 1'b1;
            end else if (lvl.close_limit) begin
               st_nxt = G_CLOSED;
               armed_nxt = 1'b0;
            end else if (want_stop) begin
               st_nxt = G_STOP;
            end
         end
         G_REV: begin
            if (gtim_r == '0) begin
               st_nxt = G_STOP; // R3
            end
         end
         G_LOCK: begin
            if (prs.lock_reset) begin
               st_nxt = G_STOP; // R21
               armed_nxt = 1'b0;
            end
         end
         default: st_nxt = G_STOP;
      endcase
   end

   // Motion drive before hand mirroring
   wire drv_open = (st_r == G_OPENING) || ((st_r == G_REV) && ro_r);
   wire drv_close = (st_r == G_CLOSING) || ((st_r == G_REV) && !ro_r);
   wire aux_on = (aux_mode == AUX_MAGLOCK) ? drv_open :
                 (aux_mode == AUX_STROBE) ? (drv_open | drv_close) :
                 (aux_mode == AUX_TICKET) ? ((st_r != G_OPEN) && (st_r != G_LOCK)) : 1'b0;

   // Gate state and drive outputs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= G_STOP;
         gtim_r <= '0;
         armed_r <= 1'b0;
         acd_r <= 1'b0;
         lo_r <= 1'b0;
         ro_r <= 1'b0;
         motor_open_r <= 1'b0;
         motor_close_r <= 1'b0;
         alarm_r <= 1'b0;
         aux_no_closed_r <= 1'b0;
         aux_nc_closed_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
         gtim_r <= gtim_nxt;
         armed_r <= armed_nxt;
         acd_r <= acd_nxt;
         lo_r <= lo_nxt;
         ro_r <= ro_nxt;
         motor_open_r <= left_hand ? drv_close : drv_open; // R18
         motor_close_r <= left_hand ? drv_open : drv_close; // R18
         alarm_r <= st_r == G_LOCK; // R5
         aux_no_closed_r <= aux_on; // R11
         aux_nc_closed_r <= !aux_on; // R11
      end
   end

   // ***************************************************
   // Programming menu
   // ***************************************************
   gic_menu_st_t mst_r, mst_nxt;
   logic [2:0] func_r, func_nxt;
   logic [3:0] edit_r, edit_nxt;
   logic [TW-1:0] mtim_r, idle_r;

   wire combo_lvl = lvl.btn_up & lvl.btn_down;
   wire combo_prs = combo_lvl & (prs.btn_up | prs.btn_down); // R13
   wire up_prs = prs.btn_up & !lvl.btn_down;
   wire dn_prs = prs.btn_down & !lvl.btn_up;
   wire step_prs = up_prs | dn_prs;
   wire btn_chg = |(deb_r[2:0] ^ deb_d_r[2:0]);
   wire in_prog = mst_r != M_IDLE;
   wire hold_cond = (mst_r == M_IDLE) ? combo_lvl : (mst_r == M_SHOW) ? lvl.btn_enter : 1'b0;
   wire [3:0] func_step = step4({1'b0, func_r}, up_prs);
   wire menu_wr = (mst_r == M_EDIT) && prs.btn_enter; // R17

   // Menu transitions; the exit combination wins over every other key
   always_comb begin
      mst_nxt = mst_r;
      func_nxt = func_r;
      edit_nxt = edit_r;
      if (mst_r != M_IDLE && (combo_prs || idle_r >= IDLE_T)) begin
         mst_nxt = M_IDLE; // R13
      end else begin
         case (mst_r)
            M_IDLE: begin
               if (mtim_r >= PROG_HOLD_T) begin
                  mst_nxt = M_FUNC; // R12
               end
            end
            M_FUNC: begin
               if (step_prs) begin
                  func_nxt = func_step[2:0]; // R14
               end else if (prs.btn_enter) begin
                  mst_nxt = M_SHOW; // R14
               end
            end
            M_SHOW: begin
               if (mtim_r >= EDIT_HOLD_T) begin
                  mst_nxt = M_EDIT; // R16
                  edit_nxt = opt_mem[func_r];
               end else if (step_prs) begin
                  mst_nxt = M_FUNC;
               end
            end
            M_EDIT: begin
               if (step_prs) begin
                  edit_nxt = step4(edit_r, up_prs); // R16
               end else if (prs.btn_enter) begin
                  mst_nxt = M_STORED; // R17
               end
            end
            M_STORED: begin
               if (step_prs || prs.btn_enter) begin
                  mst_nxt = M_FUNC; // R17
               end
            end
            default: mst_nxt = M_IDLE;
         endcase
      end
   end

   // Panel view of the menu
   wire [3:0] code_w = (mst_r == M_FUNC) ? {1'b0, func_r} :
                       (mst_r == M_EDIT) ? edit_r :
                       ((mst_r == M_SHOW) || (mst_r == M_STORED)) ? opt_mem[func_r] : 4'h0;
   wire dp_w = (mst_r == M_SHOW) || (mst_r == M_EDIT) || (mst_r == M_STORED); // R15

   // Menu state, hold and idle timers; the idle count also paces the flash
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mst_r <= M_IDLE;
         func_r <= 3'h0;
         edit_r <= 4'h0;
         mtim_r <= '0;
         idle_r <= '0;
         prog_led_r <= 1'b0;
         disp_dp_r <= 1'b0;
         disp_on_r <= 1'b0;
         disp_code_r <= 4'h0;
      end else begin
         mst_r <= mst_nxt;
         func_r <= func_nxt;
         edit_r <= edit_nxt;
         if (!hold_cond || mst_nxt != mst_r) begin
            mtim_r <= '0;
         end else if (tick_r && mtim_r != '1) begin
            mtim_r <= TW'(mtim_r + 1'b1); // R12 R16
         end
         if (!in_prog || btn_chg) begin
            idle_r <= '0;
         end else if (tick_r) begin
            idle_r <= TW'(idle_r + 1'b1); // R13
         end
         prog_led_r <= in_prog; // R12
         disp_dp_r <= dp_w;
         disp_on_r <= (mst_r == M_EDIT) ? idle_r[BLINK_BIT] : in_prog; // R16
         disp_code_r <= code_w;
      end
   end

   // ***************************************************
   // AXI4-Lite slave
   // ***************************************************
   logic aw_have_r, w_have_r;
   logic [AW-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;

   wire aw_hs = s_axi_awvalid & s_axi_awready;
   wire w_hs = s_axi_wvalid & s_axi_wready;
   wire do_wr = aw_have_r & w_have_r & !s_axi_bvalid;
   wire wr_opt = opt_hit(awaddr_r);
   wire wr_ro = (awaddr_r == REG_STATUS) || (awaddr_r == REG_INPUTS);
   wire opt_we = do_wr & wr_opt & wstrb_r[0];
   wire [2:0] opt_wi = opt_idx(awaddr_r);
   wire ar_hs = s_axi_arvalid & s_axi_arready;
   wire rd_opt = opt_hit(s_axi_araddr);
   wire [31:0] status_w = (32'(st_r) << ST_GATE_POS) | (32'(st_r == G_LOCK) << ST_LOCK_POS) |
                          (32'(in_prog) << ST_PROG_POS) | (32'(mst_r) << ST_MENU_POS) |
                          (32'(func_r) << ST_FUNC_POS);
   wire [31:0] rd_data = (s_axi_araddr == REG_STATUS) ? status_w :
                         (s_axi_araddr == REG_INPUTS) ? 32'(deb_r) :
                         rd_opt ? 32'(opt_mem[opt_idx(s_axi_araddr)]) : 32'h0000_0000;
   wire rd_ok = (s_axi_araddr == REG_STATUS) || (s_axi_araddr == REG_INPUTS) || rd_opt;

   // Write channels are taken independently; one response per address-data pair
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (aw_hs) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (w_hs) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_wr) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_opt || wr_ro) ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Read answers one cycle after the address is taken
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (ar_hs) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Option store stands in for non-volatile memory; a bus write beats a menu store
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NFUNC; i++) begin
            opt_mem[i] <= OPT_RESET; // R18
         end
      end else if (opt_we) begin
         opt_mem[opt_wi] <= wdata_r[OPT_W-1:0];
      end else if (menu_wr) begin
         opt_mem[func_r] <= edit_r; // R17
      end
   end
endmodule

/* tb/gic_gate_model.sv */
// Motor-driven gate leaf model that raises the travel limit contacts
`timescale 1ns/1ps
module gic_gate_model #(
   parameter int STEP = 32,
   parameter int SPAN = 400
) (
   // Clock, reset and motor drive
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic motor_open_r,
   input wire logic motor_close_r,
   // Limit contacts
   output logic open_limit,
   output logic close_limit
);
   int pos_r;
   int cnt_r;
   // One leaf step per STEP cycles of drive; slow so a reversal stays short of a limit
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pos_r <= SPAN / 2;
         cnt_r <= 0;
      end else if (motor_open_r ^ motor_close_r) begin
         cnt_r <= (cnt_r == STEP - 1) ? 0 : cnt_r + 1;
         if (cnt_r == STEP - 1) pos_r <= motor_open_r ? pos_r + 1 : pos_r - 1;
      end
   end
   assign open_limit = pos_r >= SPAN;
   assign close_limit = pos_r <= 0;
endmodule

/* tb/gic_gate_ctrl_assertions.sv */
// Port-level checker of the gate input and menu controller
`timescale 1ns/1ps
module gic_chk
   import gic_pkg::*;
(
   // Clock, reset and field
   input wire logic core_clk,
   input wire logic rst_n,
   input wire gic_in_t field_in,
   // Outputs and bus ready inputs watched
   input wire logic motor_open_r,
   input wire logic motor_close_r,
   input wire logic alarm_r,
   input wire logic aux_no_closed_r,
   input wire logic aux_nc_closed_r,
   input wire logic prog_led_r,
   input wire logic disp_dp_r,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   // ***************************************************
   // Properties
   // ***************************************************
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   chk_aux_pair: assert property (aux_nc_closed_r == !aux_no_closed_r) else $error("aux contacts agree");
   chk_motor_excl: assert property (!(motor_open_r && motor_close_r)) else $error("both motor drives on");
   chk_lock_still: assert property (alarm_r [*2] |-> !motor_open_r && !motor_close_r) else $error("motion in lockout");
   chk_lock_hold: assert property (alarm_r && !field_in.lock_reset |=> alarm_r) else $error("lockout left early");
   chk_dp_prog: assert property (disp_dp_r |-> prog_led_r) else $error("dp outside programming");
   chk_prog_entry: assert property ($rose(prog_led_r) |-> field_in.btn_up && field_in.btn_down) else $error("bad entry");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
   cov_lock: cover property ($rose(alarm_r));
   cov_prog: cover property ($rose(prog_led_r));
   cov_show: cover property ($rose(disp_dp_r));
endmodule

/* tb/tb_top.sv */
// Top testbench of the gate input and menu controller
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("Error %0t: mismatch", $time); end end
module tb_top
   import gic_pkg::*;
;
   logic core_clk, rst_n, open_limit, close_limit, motor_open_r, motor_close_r, alarm_r, aux_no_closed_r;
   logic aux_nc_closed_r, prog_led_r, disp_dp_r, disp_on_r, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [3:0] disp_code_r, s_axi_wstrb;
   logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] fb;
   gic_in_t field_in;
   int fails, compares, cyc;
   // Limits come from the leaf model, all else from the bench
   assign field_in = gic_in_t'({fb[15:6], open_limit, close_limit, fb[3:0]});
   gic_gate_ctrl #(.TICK_CYCLES(8)) dut (.*);
   gic_gate_model mdl (.*);
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic give_verdict;
      if (fails == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Hang guard, well above the few thousand ticks of the sequence
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         give_verdict();
      end
   end
   task automatic tk(input int n);
      repeat (n * 8) @(posedge core_clk);
   endtask
   task automatic pr(input int i);
      fb[i] <= 1'b1;
      tk(4);
      fb[i] <= 1'b0;
      tk(4);
   endtask
   // ***************************************************
   // AXI4-Lite master cycles
   // ***************************************************
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      bit aw, w;
      aw = 1;
      w = 1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw | w) begin
         @(posedge core_clk);
         if (s_axi_awready) aw = 0;
         if (s_axi_wready) w = 0;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end
      // Bready rises in the same cycle as bvalid, so the answer never waits
      @(posedge core_clk);
      s_axi_bready <= 1'b1;
      do @(posedge core_clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      `CHK(s_axi_bresp, r)
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge core_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      @(posedge core_clk);
      s_axi_rready <= 1'b1;
      do @(posedge core_clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      `CHK(s_axi_rdata, d)
      `CHK(s_axi_rresp, r)
   endtask
   // ***************************************************
   // Sequence
   // ***************************************************
   initial begin
      {fails, compares, cyc, fb, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      tk(1);
      rd(12'h000, 32'h4, RESP_OKAY);
      rd(12'h010, 32'h0, RESP_OKAY);
      wr(12'h018, 32'h2, RESP_OKAY);
      rd(12'h018, 32'h2, RESP_OKAY);
      wr(12'h200, 32'h0, RESP_SLVERR);
      rd(12'h200, 32'h0, RESP_SLVERR);
      pr(15);
      `CHK(motor_open_r, 1'b1)
      `CHK(aux_no_closed_r, 1'b1)
      tk(820);
      rd(12'h000, 32'h2, RESP_OKAY);
      pr(14);
      `CHK(motor_close_r, 1'b1)
      tk(600);
      fb[10] <= 1'b1;
      tk(5);
      fb[10] <= 1'b0;
      `CHK(motor_open_r, 1'b1)
      rd(12'h000, 32'h5, RESP_OKAY);
      tk(520);
      rd(12'h000, 32'h4, RESP_OKAY);
      pr(14);
      tk(16);
      fb[10] <= 1'b1;
      tk(5);
      fb[10] <= 1'b0;
      rd(12'h000, 32'h16, RESP_OKAY);
      `CHK(alarm_r, 1'b1)
      pr(14);
      `CHK(motor_close_r, 1'b0)
      pr(3);
      rd(12'h000, 32'h4, RESP_OKAY);
      pr(14);
      tk(16);
      pr(9);
      `CHK(motor_open_r, 1'b1)
      rd(12'h000, 32'h1, RESP_OKAY);
      fb[2:1] <= 2'h3;
      tk(1010);
      `CHK(prog_led_r, 1'b1)
      fb[2:1] <= 2'h0;
      tk(4);
      rd(12'h000, 32'h122, RESP_OKAY);
      pr(2);
      `CHK(disp_code_r, 4'h1)
      `CHK(disp_on_r, 1'b1)
      pr(0);
      `CHK(disp_dp_r, 1'b1)
      rd(12'h000, 32'h1222, RESP_OKAY);
      fb[2] <= 1'b1;
      tk(4);
      pr(1);
      `CHK(prog_led_r, 1'b0)
      give_verdict();
   end
endmodule
bind gic_gate_ctrl gic_chk u_chk (.*);
